/* dv/lpt_panel_model.sv */
module lpt_panel_model (
  // sampled panel pins
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pclk,
  input  wire logic        lclk,
  input  wire logic        fclk,
  input  wire logic        de,
  input  wire logic [15:0] d,
  // what the panel saw
  output int               npx,
  output logic [15:0]      first,
  output logic             fl,
  output int               nln
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p, l;
  int   cnt;
  // latches on the rising pixel clock, as a panel shift register does
  always @(posedge clk) begin
    p <= pclk;
    l <= lclk;
    if (rst) begin
      cnt   <= 0;
      nln   <= 0;
      npx   <= 0;
      first <= 16'h0;
      fl    <= 1'b0;
    end else begin
      if (pclk && !p && de) begin
        if (cnt == 0 && nln == 0) begin
          first <= d;
          fl    <= fclk;
        end
        cnt <= cnt + 1;
      end
      if (lclk && !l) begin
        if (nln == 0) npx <= cnt;
        cnt <= 0;
        nln <= nln + 1;
      end
    end
  end
endmodule // lpt_panel_model

/* dv/lpt_top_bench.sv */
`include "lpt_map.svh"

module lpt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lpt_pkg::*;
  typedef struct packed {
    logic [2:0]  ctl;
    logic [2:0]  dep;
    logic [11:0] pv;
    logic [15:0] pw;
    logic [15:0] px;
    logic [7:0]  np;
    logic        fl;
  } lpt_row_t;
  lpt_row_t rows [6] = '{
    '{3'h3, BPP_16, 12'h000, 16'hA5C3, 16'hA5C3, 8'h10, 1'b0},
    '{3'h3, BPP_12, 12'h000, 16'h0F00, 16'hF800, 8'h10, 1'b0},
    '{3'h3, BPP_8, 12'h088, 16'h0000, 16'h0451, 8'h10, 1'b0},
    '{3'h3, BPP_1, 12'hF00, 16'hFFFF, 16'hF800, 8'h10, 1'b0},
    '{3'h5, BPP_4, 12'h00F, 16'h0000, 16'h000F, 8'h04, 1'b1},
    '{3'h1, BPP_16, 12'h000, 16'hFFFF, 16'h00FF, 8'h06, 1'b1}
  };
  logic        clk, rst, wr, rd, fv, fr, pc, lc, fc, de, tft, fl;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] pd, first;
  logic [2:0]  dep;
  logic [11:0] pv;
  logic [15:0] pw, fd;
  int          fk, npx, nln, n, fail_count, samples_checked;

  // ==========
  // pixel word source: palette first, then frame words
  always @(posedge clk) fk <= rst ? 0 : (fv && fr) ? fk + 1 : fk;
  assign fd = fk == 0 ? {1'b0, dep, pv} :
    fk < ((dep == BPP_8) ? 256 : 16) ? {4'h0, pv} : pw;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  lpt_top i_lpt_top (.I_CLK_SYS(clk), .I_RESET(rst), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_FIFO_VALID(fv), .I_FIFO_DATA(fd), .O_FIFO_READY(fr),
    .O_PANEL_PIXEL_DATA(pd), .O_PANEL_PIXEL_CLOCK(pc), .O_PANEL_LINE_CLOCK(lc),
    .O_PANEL_FRAME_CLOCK(fc), .O_PANEL_BIAS_OR_DATA_ENABLE(de));
  lpt_panel_model i_lpt_panel_model (.clk(clk), .rst(rst), .pclk(pc), .lclk(lc),
    .fclk(fc), .de(tft ? de : 1'b1), .d(pd), .npx(npx), .first(first),
    .fl(fl), .nln(nln));

  // ==========
  // bus cycles and checks
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {rst, wr, rd, fv, tft, addr, wdata, dep, pv, pw} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`LPT_ADDR_TIM2);
    chk("div reset", 32'h3, v);
    rd_reg(`LPT_ADDR_CTRL);
    chk("ctrl reset", 32'h0, v);
    rd_reg(8'h14);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
    foreach (rows[i]) begin
      rst <= 1'b1;
      fv  <= 1'b1;
      dep <= rows[i].dep;
      pv  <= rows[i].pv;
      pw  <= rows[i].pw;
      tft <= rows[i].ctl[1];
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wr_reg(`LPT_ADDR_TIM0, rows[i].ctl[1] ? 32'h00010100 : 32'h01000000);
      wr_reg(`LPT_ADDR_TIM1, 32'h00010001);
      wr_reg(`LPT_ADDR_TIM2, rows[i].ctl[1] ? 32'h0 : 32'h5);
      wr_reg(`LPT_ADDR_CTRL, {29'h0, rows[i].ctl});
      n = 0;
      while (nln < 4 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      if (n == 20000) begin
        fail_count++;
        final_report;
      end
      chk("pixels per line", {24'h0, rows[i].np}, npx);
      chk("first pixel", {16'h0, rows[i].px}, {16'h0, first});
      chk("frame clock", {31'h0, rows[i].fl}, {31'h0, fl});
      rd_reg(`LPT_ADDR_STATUS);
      chk("status", {27'h0, rows[i].dep, 2'b01}, v & 32'h1F);
      $display("test row %0d done", i);
    end
    // starve the source mid-line, then clear the sticky flag
    fv <= 1'b0;
    repeat (300) @(posedge clk);
    rd_reg(`LPT_ADDR_STATUS);
    chk("underflow", 32'h2, v & 32'h2);
    fv <= 1'b1;
    repeat (100) @(posedge clk);
    wr_reg(`LPT_ADDR_STATUS, 32'h2);
    rd_reg(`LPT_ADDR_STATUS);
    chk("underflow cleared", 32'h0, v & 32'h2);
    $display("test underflow done");
    // bias count of zero: ac-bias flips at every line clock
    wr_reg(`LPT_ADDR_CTRL, 32'h9);
    @(posedge clk);
    v = {31'h0, de};
    n = 0;
    while (!lc && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (lc && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) fail_count++;
    chk("bias toggle", v ^ 32'h1, {31'h0, de});
    $display("test bias done");
    final_report;
  end
endmodule // lpt_top_bench

/* dv/lpt_top_sva.sv */
`include "lpt_map.svh"

module lpt_top_sva
  import lpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // all ports of the top, seen as inputs
  input wire logic              I_CLK_SYS,
  input wire logic              I_RESET,
  input wire logic [ADDR_W-1:0] I_REG_ADDR,
  input wire logic [31:0]       I_REG_WDATA,
  input wire logic              I_REG_WR,
  input wire logic              I_REG_RD,
  input wire logic [31:0]       O_REG_RDATA,
  input wire logic              I_FIFO_VALID,
  input wire logic [15:0]       I_FIFO_DATA,
  input wire logic              O_FIFO_READY,
  input wire logic [15:0]       O_PANEL_PIXEL_DATA,
  input wire logic              O_PANEL_PIXEL_CLOCK,
  input wire logic              O_PANEL_LINE_CLOCK,
  input wire logic              O_PANEL_FRAME_CLOCK,
  input wire logic              O_PANEL_BIAS_OR_DATA_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadow of the settings, snooped from register writes, plus a count of line clock high cycles
  logic [31:0] ctl, t0, t2;
  int          lc;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      ctl <= '0;
      t0  <= '0;
      t2  <= 32'h3;
      lc  <= 0;
    end else begin
      if (I_REG_WR && I_REG_ADDR == `LPT_ADDR_CTRL) ctl <= I_REG_WDATA;
      if (I_REG_WR && I_REG_ADDR == `LPT_ADDR_TIM0) t0 <= I_REG_WDATA;
      if (I_REG_WR && I_REG_ADDR == `LPT_ADDR_TIM2) t2 <= I_REG_WDATA;
      lc <= O_PANEL_LINE_CLOCK ? lc + 1 : 0;
    end
  end

  // ==========
  // properties
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  a_rdata_one_cycle: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h0)
    else $error("read data outside its cycle");
  a_reset_quiet: assert property (disable iff (1'b0) I_RESET |=>
    O_PANEL_PIXEL_DATA == 16'h0 && !O_PANEL_PIXEL_CLOCK && !O_PANEL_LINE_CLOCK
    && !O_PANEL_FRAME_CLOCK && !O_PANEL_BIAS_OR_DATA_ENABLE && !O_FIFO_READY)
    else $error("panel active in reset");
  a_idle_quiet: assert property (!ctl[0] |-> !O_PANEL_PIXEL_CLOCK &&
    !O_PANEL_LINE_CLOCK && !O_PANEL_FRAME_CLOCK && !O_FIFO_READY)
    else $error("panel active while disabled");
  a_mono_lanes: assert property (ctl[0] && !ctl[1] && ctl[2] |->
    O_PANEL_PIXEL_DATA[15:4] == 12'h0) else $error("mono upper lanes driven");
  a_color_lanes: assert property (ctl[0] && !ctl[1] |->
    O_PANEL_PIXEL_DATA[15:8] == 8'h0) else $error("passive upper lanes driven");
  a_line_pclk_still: assert property (ctl[0] && !ctl[1] && O_PANEL_LINE_CLOCK
    |-> !O_PANEL_PIXEL_CLOCK) else $error("pixel clock during line clock");
  a_enable_edge: assert property (ctl[1] && $rose(O_PANEL_BIAS_OR_DATA_ENABLE)
    |-> !O_PANEL_PIXEL_CLOCK) else $error("enable not on falling clock");
  a_line_width: assert property ($fell(O_PANEL_LINE_CLOCK) |-> lc ==
    (int'(t0[31:24]) + 1) * 2 * (int'(t2[7:0]) + 1))
    else $error("line clock width wrong");
  a_bias_on_line: assert property (ctl[0] && !ctl[1] &&
    $changed(O_PANEL_BIAS_OR_DATA_ENABLE) |-> $fell(O_PANEL_LINE_CLOCK))
    else $error("bias moved off a line clock");
  a_vsync_after_line: assert property (ctl[0] && ctl[1] &&
    $rose(O_PANEL_FRAME_CLOCK) |-> $fell(O_PANEL_LINE_CLOCK))
    else $error("frame clock not after line clock");
endmodule // lpt_top_sva

bind lpt_top lpt_top_sva #(.ADDR_W(ADDR_W)) i_lpt_top_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA), .I_FIFO_VALID(I_FIFO_VALID), .I_FIFO_DATA(I_FIFO_DATA),
  .O_FIFO_READY(O_FIFO_READY), .O_PANEL_PIXEL_DATA(O_PANEL_PIXEL_DATA),
  .O_PANEL_PIXEL_CLOCK(O_PANEL_PIXEL_CLOCK), .O_PANEL_LINE_CLOCK(O_PANEL_LINE_CLOCK),
  .O_PANEL_FRAME_CLOCK(O_PANEL_FRAME_CLOCK),
  .O_PANEL_BIAS_OR_DATA_ENABLE(O_PANEL_BIAS_OR_DATA_ENABLE));

/* verilog/lpt_map.svh */
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define LPT_ADDR_CTRL        8'h00
`define LPT_ADDR_TIM0        8'h04
`define LPT_ADDR_TIM1        8'h08
`define LPT_ADDR_TIM2        8'h0C
`define LPT_ADDR_STATUS      8'h10

// ==========================================================
// control register bits
`define LPT_CTRL_EN          0
`define LPT_CTRL_ACTIVE      1
`define LPT_CTRL_MONO        2
`define LPT_CTRL_BIAS_EN     3
`define LPT_CTRL_RELOAD      4

// ==========================================================
// timing register fields
`define LPT_T0_PPL_MSB       5
`define LPT_T0_PPL_LSB       0
`define LPT_T0_FRONT_MSB     15
`define LPT_T0_FRONT_LSB     8
`define LPT_T0_BACK_MSB      23
`define LPT_T0_BACK_LSB      16
`define LPT_T0_LWIDTH_MSB    31
`define LPT_T0_LWIDTH_LSB    24
`define LPT_T1_LINES_MSB     9
`define LPT_T1_LINES_LSB     0
`define LPT_T1_VWAIT_MSB     23
`define LPT_T1_VWAIT_LSB     16
`define LPT_T2_DIV_MSB       7
`define LPT_T2_DIV_LSB       0
`define LPT_T2_BIAS_MSB      15
`define LPT_T2_BIAS_LSB      8

// ==========================================================
// status register fields
`define LPT_ST_RUN           0
`define LPT_ST_UNDER         1
`define LPT_ST_DEPTH_MSB     4
`define LPT_ST_DEPTH_LSB     2
`define LPT_ST_LINE_MSB      26
`define LPT_ST_LINE_LSB      16

// ==========================================================
// palette word layout and sizes
`define LPT_PAL_DEPTH_MSB    14
`define LPT_PAL_DEPTH_LSB    12
`define LPT_PAL_LAST_SMALL   9'h00F
`define LPT_PAL_LAST_LARGE   9'h0FF

// ==========================================================
// reset values
`define LPT_PPL_RST          6'h00
`define LPT_LINES_RST        10'h000
`define LPT_DIV_RST          8'h03
`define LPT_LWIDTH_RST       8'h00

// ==========================================================
// dither: fifteen levels share a fourteen-frame cycle
`define LPT_DITHER_PERIOD    6'h0E
`define LPT_DITHER_LAST      4'hD

`endif

/* verilog/lpt_pkg.sv */
package lpt_pkg;

  // ==========================================================
  // enumerations
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_PAL    = 7'h02,
    ST_PRIME  = 7'h04,
    ST_LSTART = 7'h08,
    ST_DATA   = 7'h10,
    ST_LEND   = 7'h20,
    ST_LCLK   = 7'h40
  } lpt_state_t;

  typedef enum logic [2:0] {
    BPP_1  = 3'h0,
    BPP_2  = 3'h1,
    BPP_4  = 3'h2,
    BPP_8  = 3'h3,
    BPP_12 = 3'h4,
    BPP_16 = 3'h5
  } lpt_depth_t;

  // ==========================================================
  // panel pins
  typedef struct packed {
    logic [15:0] data;
    logic        pclk;
    logic        lclk;
    logic        fclk;
    logic        bias;
  } lpt_panel_t;

  // ==========================================================
  // whole state of the controller
  typedef struct packed {
    lpt_state_t          st;
    logic                en;
    logic                tft;
    logic                mono;
    logic                bias_en;
    logic                reload;
    logic [5:0]          ppl_code;
    logic [7:0]          front;
    logic [7:0]          back;
    logic [7:0]          lwidth;
    logic [9:0]          lines;
    logic [7:0]          vwait;
    logic [7:0]          div;
    logic [7:0]          bias_n;
    logic [31:0]         rdata;
    lpt_depth_t          depth;
    logic [255:0][11:0]  pal;
    logic [8:0]          pal_idx;
    logic [15:0]         word;
    logic [4:0]          wbits;
    logic [15:0]         stage;
    logic                full;
    logic [2:0]          elem;
    logic [1:0]          sub;
    logic [21:0]         prod;
    logic [7:0]          half;
    logic                ph;
    logic [10:0]         line;
    logic [10:0]         cnt;
    logic [3:0]          frm;
    logic [7:0]          bias_cnt;
    logic                bias;
    logic                under;
    lpt_panel_t          pan;
  } lpt_core_t;

endpackage

/* verilog/lpt_top.sv */
// Operation
// - one panel only, no split halves
// - line length 16 to 1024, steps of 16
// - frame up to 1024 by 1024
// - depths 1-16, palette 16/256 or bypass
// - mono passive: dithered low nibble, 4 lines
// - color passive: one dither shared by three channels, 8 lines
// - 12/16 bit passive bypasses palette
// - active <=8 bit: palette widened to 16
// - active 12 bit: frame data widened to 16
// - active 16 bit passes unchanged
// - lanes [3:0], [7:0] or [15:0]
// - passive pixel clock only with data
// - active pixel clock free, bias is enable
// - line clock after pixels, porch waits
// - passive frame clock on first line
// - active frame clock after vertical waits
// - passive pixel clock still during waits
// - bias inverts every programmed line count plus one
// - pixel clock divided from system clock
// - line/frame clocks act as syncs
// - each fifo request gives 16 bits
// - palette entry 0 holds depth code
`include "lpt_map.svh"

module lpt_top
  import lpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RESET,
  // register port
  input  wire logic [ADDR_W-1:0] I_REG_ADDR,
  input  wire logic [31:0]       I_REG_WDATA,
  input  wire logic              I_REG_WR,
  input  wire logic              I_REG_RD,
  output logic      [31:0]       O_REG_RDATA,
  // pixel word fifo
  input  wire logic              I_FIFO_VALID,
  input  wire logic [15:0]       I_FIFO_DATA,
  output logic                   O_FIFO_READY,
  // panel
  output logic      [15:0]       O_PANEL_PIXEL_DATA,
  output logic                   O_PANEL_PIXEL_CLOCK,
  output logic                   O_PANEL_LINE_CLOCK,
  output logic                   O_PANEL_FRAME_CLOCK,
  output logic                   O_PANEL_BIAS_OR_DATA_ENABLE
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] mod14(input logic [5:0] v);
    logic [5:0] r;
    r = v;
    if (r >= `LPT_DITHER_PERIOD) r = r - `LPT_DITHER_PERIOD;
    if (r >= `LPT_DITHER_PERIOD) r = r - `LPT_DITHER_PERIOD;
    return r[3:0];
  endfunction

  // levels 0 and 1 both stay dark, giving fifteen distinct duties
  function automatic logic dith(input logic [3:0] g, input logic [3:0] phase);
    logic [3:0] eff;
    eff = (g == 4'h0) ? 4'h0 : g - 4'h1;
    return phase < eff;
  endfunction

  function automatic logic [3:0] chan(input logic [11:0] c, input logic [1:0] sel);
    logic [3:0] r;
    r = c[3:0];
    if (sel == 2'h0) r = c[11:8];
    else if (sel == 2'h1) r = c[7:4];
    return r;
  endfunction

  function automatic logic [4:0] step(input lpt_depth_t d);
    logic [4:0] r;
    case (d)
      BPP_1:   r = 5'h01;
      BPP_2:   r = 5'h02;
      BPP_4:   r = 5'h04;
      BPP_8:   r = 5'h08;
      default: r = 5'h10;
    endcase
    return r;
  endfunction

  // ==========================================================
  // state and combinational terms
  lpt_core_t   s;
  lpt_core_t   n;
  logic        tick;
  logic        slot_end;
  logic        fetch_ok;
  logic        fifo_rdy;
  logic        take;
  logic        consume;
  logic        start_data;
  logic        data_slot;
  logic        line_state;
  logic [7:0]  pix_idx;
  logic [11:0] pal_val;
  logic [11:0] col12;
  logic [3:0]  gray;
  logic [15:0] act_val;
  logic [3:0]  phase;
  logic [6:0]  np1;
  logic [10:0] sets;
  logic [21:0] frame_sets;
  logic [10:0] last_line;
  logic [8:0]  pal_last;
  lpt_depth_t  new_depth;

  always_comb begin
    n          = s;
    n.rdata    = '0;
    consume    = 1'b0;
    start_data = 1'b0;

    // ========================================================
    // register writes
    if (I_REG_WR) begin
      if (I_REG_ADDR == `LPT_ADDR_CTRL) begin
        n.en      = I_REG_WDATA[`LPT_CTRL_EN];
        n.tft     = I_REG_WDATA[`LPT_CTRL_ACTIVE];
        n.mono    = I_REG_WDATA[`LPT_CTRL_MONO];
        n.bias_en = I_REG_WDATA[`LPT_CTRL_BIAS_EN];
        n.reload  = I_REG_WDATA[`LPT_CTRL_RELOAD];
      end else if (I_REG_ADDR == `LPT_ADDR_TIM0) begin
        n.ppl_code = I_REG_WDATA[`LPT_T0_PPL_MSB:`LPT_T0_PPL_LSB];
        n.front    = I_REG_WDATA[`LPT_T0_FRONT_MSB:`LPT_T0_FRONT_LSB];
        n.back     = I_REG_WDATA[`LPT_T0_BACK_MSB:`LPT_T0_BACK_LSB];
        n.lwidth   = I_REG_WDATA[`LPT_T0_LWIDTH_MSB:`LPT_T0_LWIDTH_LSB];
      end else if (I_REG_ADDR == `LPT_ADDR_TIM1) begin
        n.lines = I_REG_WDATA[`LPT_T1_LINES_MSB:`LPT_T1_LINES_LSB];
        n.vwait = I_REG_WDATA[`LPT_T1_VWAIT_MSB:`LPT_T1_VWAIT_LSB];
      end else if (I_REG_ADDR == `LPT_ADDR_TIM2) begin
        n.div    = I_REG_WDATA[`LPT_T2_DIV_MSB:`LPT_T2_DIV_LSB];
        n.bias_n = I_REG_WDATA[`LPT_T2_BIAS_MSB:`LPT_T2_BIAS_LSB];
      end else if (I_REG_ADDR == `LPT_ADDR_STATUS) begin
        if (I_REG_WDATA[`LPT_ST_UNDER]) n.under = 1'b0;
      end
    end

    // ========================================================
    // register reads, data valid in the next cycle only
    if (I_REG_RD) begin
      if (I_REG_ADDR == `LPT_ADDR_CTRL) begin
        n.rdata[`LPT_CTRL_EN]      = s.en;
        n.rdata[`LPT_CTRL_ACTIVE]  = s.tft;
        n.rdata[`LPT_CTRL_MONO]    = s.mono;
        n.rdata[`LPT_CTRL_BIAS_EN] = s.bias_en;
        n.rdata[`LPT_CTRL_RELOAD]  = s.reload;
      end else if (I_REG_ADDR == `LPT_ADDR_TIM0) begin
        n.rdata = {s.lwidth, s.back, s.front, 2'h0, s.ppl_code};
      end else if (I_REG_ADDR == `LPT_ADDR_TIM1) begin
        n.rdata = {8'h00, s.vwait, 6'h00, s.lines};
      end else if (I_REG_ADDR == `LPT_ADDR_TIM2) begin
        n.rdata = {16'h0000, s.bias_n, s.div};
      end else if (I_REG_ADDR == `LPT_ADDR_STATUS) begin
        n.rdata[`LPT_ST_RUN]                           = (s.st != ST_IDLE);
        n.rdata[`LPT_ST_UNDER]                         = s.under;
        n.rdata[`LPT_ST_DEPTH_MSB:`LPT_ST_DEPTH_LSB]   = s.depth;
        n.rdata[`LPT_ST_LINE_MSB:`LPT_ST_LINE_LSB]     = s.line;
      end
    end

    // ========================================================
    // geometry: sets per line depend on lanes per pixel clock
    np1 = {1'b0, s.ppl_code} + 7'h01;
    if (s.tft) sets = {np1, 4'h0};
    else if (s.mono) sets = {2'b00, np1, 2'b00};
    else sets = {2'b00, np1, 2'b00} + {3'b000, np1, 1'b0};
    frame_sets = 22'(sets) * 22'({1'b0, s.lines} + 11'h001);
    last_line  = {1'b0, s.lines} + {3'b000, s.vwait} + {10'h000, s.tft};

    // ========================================================
    // pixel clock divider: one slot is two half periods
    tick     = (s.half == s.div);
    slot_end = tick & s.ph;
    n.half   = tick ? 8'h00 : s.half + 8'h01;
    if (tick) n.ph = ~s.ph;

    // ========================================================
    // fifo fetch: one 16-bit word per accepted request
    fetch_ok = (s.st != ST_IDLE) && (s.st != ST_PAL) && (s.prod != frame_sets);
    fifo_rdy = (s.st == ST_PAL) || (fetch_ok && (s.wbits == 5'h00));
    take     = I_FIFO_VALID & fifo_rdy;
    if (take && (s.st != ST_PAL)) begin
      n.word  = I_FIFO_DATA;
      n.wbits = 5'h10;
    end

    // ========================================================
    // pixel lookup, first pixel in the low bits of a word
    case (s.depth)
      BPP_1:   pix_idx = {7'h00, s.word[0]};
      BPP_2:   pix_idx = {6'h00, s.word[1:0]};
      BPP_4:   pix_idx = {4'h0, s.word[3:0]};
      default: pix_idx = s.word[7:0];
    endcase
    pal_val = s.pal[pix_idx];
    if (s.depth == BPP_12) col12 = s.word[11:0];
    else if (s.depth == BPP_16) col12 = {s.word[15:12], s.word[10:7], s.word[4:1]};
    else col12 = pal_val;
    gray = ((s.depth == BPP_12) || (s.depth == BPP_16)) ? s.word[3:0] : pal_val[3:0];
    if (s.depth == BPP_16) act_val = s.word;
    else act_val = {col12[11:8], col12[11], col12[7:4], col12[7:6],
                    col12[3:0], col12[3]};
    phase = mod14({2'b00, s.frm} + {2'b00, s.prod[3:0]} + {3'b000, s.elem});

    // ========================================================
    // producer: builds the next data set while the current one shows
    if (fetch_ok && !s.full && (s.wbits != 5'h00)) begin
      if (s.tft) begin
        n.stage = act_val;
        n.full  = 1'b1;
        consume = 1'b1;
      end else if (s.mono) begin
        if (s.elem == 3'h0) n.stage = 16'h0000;
        n.stage[s.elem] = dith(gray, phase);
        consume = 1'b1;
        n.full  = (s.elem == 3'h3);
        n.elem  = n.full ? 3'h0 : s.elem + 3'h1;
      end else begin
        if (s.elem == 3'h0) n.stage = 16'h0000;
        n.stage[s.elem] = dith(chan(col12, s.sub), phase);
        consume = (s.sub == 2'h2);
        n.sub   = consume ? 2'h0 : s.sub + 2'h1;
        n.full  = (s.elem == 3'h7);
        n.elem  = s.elem + 3'h1;
      end
      if (consume) begin
        n.word  = s.word >> step(s.depth);
        n.wbits = s.wbits - step(s.depth);
      end
      if (n.full) n.prod = s.prod + 22'h000001;
    end

    // ========================================================
    // timing generator
    new_depth = lpt_depth_t'(I_FIFO_DATA[`LPT_PAL_DEPTH_MSB:`LPT_PAL_DEPTH_LSB]);
    pal_last  = (((s.pal_idx == 9'h000) ? new_depth : s.depth) == BPP_8) ?
                `LPT_PAL_LAST_LARGE : `LPT_PAL_LAST_SMALL;
    case (s.st)
      ST_IDLE: begin
        n.half    = 8'h00;
        n.ph      = 1'b0;
        n.line    = 11'h000;
        n.cnt     = 11'h000;
        n.pal_idx = 9'h000;
        n.full    = 1'b0;
        n.wbits   = 5'h00;
        n.elem    = 3'h0;
        n.sub     = 2'h0;
        n.prod    = 22'h000000;
        if (s.en) n.st = ST_PAL;
      end
      ST_PAL: begin
        if (take) begin
          if (s.pal_idx == 9'h000) n.depth = new_depth;
          n.pal[s.pal_idx[7:0]] = I_FIFO_DATA[11:0];
          n.pal_idx = s.pal_idx + 9'h001;
          if (s.pal_idx == pal_last) n.st = ST_PRIME;
        end
      end
      ST_PRIME: begin
        if (s.full && slot_end) begin
          n.cnt = 11'h000;
          if (s.back == 8'h00) begin
            n.st       = ST_DATA;
            start_data = 1'b1;
          end else begin
            n.st = ST_LSTART;
          end
        end
      end
      ST_LSTART: begin
        if (slot_end) begin
          if (s.cnt + 11'h001 >= {3'b000, s.back}) begin
            n.cnt      = 11'h000;
            n.st       = ST_DATA;
            start_data = 1'b1;
          end else begin
            n.cnt = s.cnt + 11'h001;
          end
        end
      end
      ST_DATA: begin
        if (slot_end) begin
          if (s.cnt + 11'h001 >= sets) begin
            n.cnt = 11'h000;
            n.st  = (s.front == 8'h00) ? ST_LCLK : ST_LEND;
          end else begin
            n.cnt      = s.cnt + 11'h001;
            start_data = 1'b1;
          end
        end
      end
      ST_LEND: begin
        if (slot_end) begin
          if (s.cnt + 11'h001 >= {3'b000, s.front}) begin
            n.cnt = 11'h000;
            n.st  = ST_LCLK;
          end else begin
            n.cnt = s.cnt + 11'h001;
          end
        end
      end
      ST_LCLK: begin
        if (slot_end) begin
          if (s.cnt >= {3'b000, s.lwidth}) begin
            n.cnt = 11'h000;
            if (s.bias_en) begin
              if (s.bias_cnt >= s.bias_n) begin
                n.bias     = ~s.bias;
                n.bias_cnt = 8'h00;
              end else begin
                n.bias_cnt = s.bias_cnt + 8'h01;
              end
            end
            if (s.line >= last_line) begin
              n.line    = 11'h000;
              n.frm     = (s.frm == `LPT_DITHER_LAST) ? 4'h0 : s.frm + 4'h1;
              n.prod    = 22'h000000;
              n.pal_idx = 9'h000;
              n.st      = s.reload ? ST_PAL : ST_PRIME;
            end else begin
              n.line = s.line + 11'h001;
              if (s.back == 8'h00) begin
                n.st       = ST_DATA;
                start_data = 1'b1;
              end else begin
                n.st = ST_LSTART;
              end
            end
          end else begin
            n.cnt = s.cnt + 11'h001;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // ========================================================
    // hand the finished set to the pins; blank lines carry none
    if (start_data && (n.line <= {1'b0, s.lines})) begin
      if (n.full) begin
        n.pan.data = n.stage;
        n.full     = 1'b0;
      end else begin
        n.under = 1'b1;
      end
    end

    // disable takes effect at once; a running frame is abandoned
    if (!n.en) begin
      n.st       = ST_IDLE;
      n.ph       = 1'b0;
      n.bias     = 1'b0;
      n.bias_cnt = 8'h00;
      n.pan.data = 16'h0000;
    end

    // ========================================================
    // pins follow the next state so data and clock stay aligned
    line_state = (n.st == ST_LSTART) || (n.st == ST_DATA) ||
                 (n.st == ST_LEND) || (n.st == ST_LCLK);
    data_slot  = (n.st == ST_DATA) && (n.line <= {1'b0, s.lines});
    n.pan.pclk = n.ph && (n.st != ST_IDLE) && (s.tft || data_slot);
    n.pan.lclk = (n.st == ST_LCLK);
    n.pan.fclk = line_state &&
                 (s.tft ? (n.line == last_line) : (n.line == 11'h000));
    n.pan.bias = s.tft ? data_slot : n.bias;
  end

  // ==========================================================
  // state register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.ppl_code <= `LPT_PPL_RST;
      s.lines    <= `LPT_LINES_RST;
      s.div      <= `LPT_DIV_RST;
      s.lwidth   <= `LPT_LWIDTH_RST;
      s.depth    <= BPP_1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs; single panel only, so one set of pins
  assign O_REG_RDATA                 = s.rdata;
  assign O_FIFO_READY                = fifo_rdy;
  assign O_PANEL_PIXEL_DATA          = s.pan.data;
  assign O_PANEL_PIXEL_CLOCK         = s.pan.pclk;
  assign O_PANEL_LINE_CLOCK          = s.pan.lclk;
  assign O_PANEL_FRAME_CLOCK         = s.pan.fclk;
  assign O_PANEL_BIAS_OR_DATA_ENABLE = s.pan.bias;

endmodule // lpt_top
